// file: hdl/card_cfg_pkg.sv
// Shared constants and types for the card socket configuration registers
package card_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SKT_N = 2;
  localparam int IRQ_W = 4;

  // Register byte offsets
  localparam logic [7:0] CLASS_CODE_OFS = 8'h54;
  localparam logic [7:0] SOCKET_CFG_OFS = 8'h58;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h60;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h64;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h68;

  // Class code copy
  localparam logic [31:0] CLASS_CODE_RST = 32'h07800000;
  localparam logic [31:0] CLASS_CODE_WMASK = 32'hffffffc0;

  // Socket configuration: printed default, writable bits, fixed ones
  localparam logic [31:0] SOCKET_CFG_RST = 32'h03743307;
  localparam logic [31:0] SOCKET_CFG_WMASK = 32'hf3333033;
  localparam logic [31:0] SOCKET_CFG_ONES = 32'h00000300;
  localparam logic [31:0] SKT2_MASK = 32'h04444444;
  localparam logic [31:0] SKT3_MASK = 32'h08888888;

  // Field positions, two implemented sockets per field except the four-bit scratch field at bits 31 to 28
  localparam int SCRATCH_LSB = 28;
  localparam int LOWV_LSB = 24;
  localparam int HIGHV_LSB = 20;
  localparam int PAYMENT_LSB = 16;
  localparam int AUX_LSB = 12;
  localparam int DEDICATED_LSB = 8;
  localparam int WAKE_LSB = 4;
  localparam int ENABLE_LSB = 0;

  // Interrupt status layout
  localparam int IRQ_INSERT_LSB = 0;
  localparam int IRQ_WAKE_LSB = 2;
  localparam logic [3:0] IRQ_RST = 4'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic load;
    logic [7:0] addr;
    logic [31:0] data;
  } ee_load_t;

  typedef struct packed {
    logic [1:0] enable;
    logic [1:0] lowv;
    logic [1:0] highv;
    logic [1:0] payment;
    logic [1:0] aux;
    logic [1:0] dedicated;
    logic [1:0] wake;
  } socket_ctl_t;

  typedef struct packed {
    logic [31:0] class_code;
    logic [31:0] socket_cfg;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic [31:0] rd_data;
    logic [1:0] insert_prev;
    logic insert_valid;
    logic [1:0] wake_pulse;
  } cfg_state_t;

  localparam cfg_state_t CFG_STATE_RST = '{
    class_code: CLASS_CODE_RST & CLASS_CODE_WMASK,
    socket_cfg: (SOCKET_CFG_RST & SOCKET_CFG_WMASK) | SOCKET_CFG_ONES,
    irq_status: IRQ_RST,
    irq_enable: IRQ_RST,
    rd_data: 32'h00000000,
    insert_prev: 2'h0,
    insert_valid: 1'b0,
    wake_pulse: 2'h0
  };

endpackage : card_cfg_pkg

// file: hdl/pin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync
#(
  parameter int WIDTH = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.meta = pin_i;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= '0;
    else if (ce_i)
      state_r <= state_nxt;
  end

  assign sync_o = state_r.stable;

endmodule : pin_sync

// file: hdl/card_cfg_regs.sv
// Class code copy and card socket configuration register block
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Function
// - Class code copy is writable, loader-preloadable, resets to 07800000h
// - Socket configuration is mirrored to a read alias output
// - Only the global reset returns configuration to defaults
// - Bits 25 and 24 flag low voltage class support, sockets 1 and 0
// - Bits 21 and 20 flag high voltage class support, sockets 1 and 0
// - Bits 17 and 16 enable payment interface logic per socket
// - Bits 13 and 12 enable auxiliary card pins per socket
// - Bits 9 and 8 are read-only ones: dedicated sockets
// - Bits 5 and 4 let card insertion raise a wake event
// - Bits 1 and 0 enable sockets 1 and 0
// - Socket 3 bits read zero and ignore writes
// - Socket 2 bits read zero and ignore writes
module card_cfg_regs
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic FUNC_RST_I,
  input wire card_cfg_pkg::bus_req_t BUS_I,
  output logic [31:0] RD_DATA_O,
  input wire card_cfg_pkg::ee_load_t EE_I,
  input wire logic [1:0] CARD_INSERT_I,
  output logic [31:0] CLASS_CODE_O,
  output logic [31:0] ALIAS_CFG_O,
  output card_cfg_pkg::socket_ctl_t SOCKET_O,
  output logic [1:0] WAKE_O,
  output logic IRQ_O
);

  card_cfg_pkg::cfg_state_t state_r;
  card_cfg_pkg::cfg_state_t state_nxt;
  logic [1:0] insert_sync;
  logic [1:0] insert_rise;
  logic [1:0] wake_en;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;

  // Card detect pins cross into the clock domain
  pin_sync
  #(
    .WIDTH(card_cfg_pkg::SKT_N)
  )
  u_insert_sync
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .pin_i(CARD_INSERT_I),
    .sync_o(insert_sync)
  );

  assign wake_en = state_r.socket_cfg[card_cfg_pkg::WAKE_LSB +: 2];
  assign insert_rise = insert_sync & ~state_r.insert_prev
    & {2{state_r.insert_valid}};
  assign irq_set = {insert_rise & wake_en, insert_rise};
  assign irq_clr = (BUS_I.wr && BUS_I.addr == card_cfg_pkg::IRQ_CLEAR_OFS)
    ? BUS_I.wdata[3:0] : 4'h0;

  always_comb
  begin
    state_nxt = state_r;
    // Insertion edge tracking
    state_nxt.insert_prev = insert_sync;
    state_nxt.insert_valid = 1'b1;
    state_nxt.wake_pulse = insert_rise & wake_en;
    // Sticky status, set beats clear
    state_nxt.irq_status = (state_r.irq_status & ~irq_clr) | irq_set;
    // Serial loader preload
    if (EE_I.load)
    begin
      unique case (EE_I.addr)
        card_cfg_pkg::CLASS_CODE_OFS:
          state_nxt.class_code = EE_I.data
            & card_cfg_pkg::CLASS_CODE_WMASK;
        card_cfg_pkg::SOCKET_CFG_OFS:
          state_nxt.socket_cfg = (EE_I.data
            & card_cfg_pkg::SOCKET_CFG_WMASK)
            | card_cfg_pkg::SOCKET_CFG_ONES;
        default:
          state_nxt.class_code = state_nxt.class_code;
      endcase
    end
    // Register writes, bus wins over loader
    if (BUS_I.wr)
    begin
      unique case (BUS_I.addr)
        card_cfg_pkg::CLASS_CODE_OFS:
          state_nxt.class_code = BUS_I.wdata
            & card_cfg_pkg::CLASS_CODE_WMASK;
        card_cfg_pkg::SOCKET_CFG_OFS:
          state_nxt.socket_cfg = (BUS_I.wdata
            & card_cfg_pkg::SOCKET_CFG_WMASK)
            | card_cfg_pkg::SOCKET_CFG_ONES;
        card_cfg_pkg::IRQ_ENABLE_OFS:
          state_nxt.irq_enable = BUS_I.wdata[3:0];
        default:
          state_nxt.irq_enable = state_nxt.irq_enable;
      endcase
    end
    // Read data for the following cycle only
    state_nxt.rd_data = 32'h00000000;
    if (BUS_I.rd)
    begin
      unique case (BUS_I.addr)
        card_cfg_pkg::CLASS_CODE_OFS:
          state_nxt.rd_data = state_r.class_code;
        card_cfg_pkg::SOCKET_CFG_OFS:
          state_nxt.rd_data = state_r.socket_cfg;
        card_cfg_pkg::IRQ_STATUS_OFS:
          state_nxt.rd_data = {28'h0000000, state_r.irq_status};
        card_cfg_pkg::IRQ_ENABLE_OFS:
          state_nxt.rd_data = {28'h0000000, state_r.irq_enable};
        default:
          state_nxt.rd_data = 32'h00000000;
      endcase
    end
    // Function reset spares the configuration
    if (FUNC_RST_I)
    begin
      state_nxt.irq_status = card_cfg_pkg::IRQ_RST;
      state_nxt.irq_enable = card_cfg_pkg::IRQ_RST;
      state_nxt.wake_pulse = 2'h0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      state_r <= card_cfg_pkg::CFG_STATE_RST;
    else if (CE_I)
      state_r <= state_nxt;
  end

  // Outputs
  assign RD_DATA_O = state_r.rd_data;
  assign CLASS_CODE_O = state_r.class_code;
  assign ALIAS_CFG_O = state_r.socket_cfg;
  assign WAKE_O = state_r.wake_pulse;
  assign IRQ_O = |(state_r.irq_status & state_r.irq_enable);

  always_comb
  begin
    SOCKET_O.enable =
      state_r.socket_cfg[card_cfg_pkg::ENABLE_LSB +: 2];
    SOCKET_O.lowv =
      state_r.socket_cfg[card_cfg_pkg::LOWV_LSB +: 2];
    SOCKET_O.highv =
      state_r.socket_cfg[card_cfg_pkg::HIGHV_LSB +: 2];
    SOCKET_O.payment =
      state_r.socket_cfg[card_cfg_pkg::PAYMENT_LSB +: 2];
    SOCKET_O.aux =
      state_r.socket_cfg[card_cfg_pkg::AUX_LSB +: 2];
    SOCKET_O.dedicated =
      state_r.socket_cfg[card_cfg_pkg::DEDICATED_LSB +: 2];
    SOCKET_O.wake = wake_en;
  end

  // Checks
  default clocking cb @(posedge CLK_I);
  endclocking

  default disable iff (RST_I);

  sequence s_class_wr;
    CE_I && BUS_I.wr && BUS_I.addr == card_cfg_pkg::CLASS_CODE_OFS;
  endsequence

  sequence s_class_load;
    CE_I && EE_I.load && !BUS_I.wr
      && EE_I.addr == card_cfg_pkg::CLASS_CODE_OFS;
  endsequence

  sequence s_cfg_wr;
    CE_I && BUS_I.wr && BUS_I.addr == card_cfg_pkg::SOCKET_CFG_OFS;
  endsequence

  sequence s_cfg_rd;
    CE_I && BUS_I.rd && !EE_I.load
      && BUS_I.addr == card_cfg_pkg::SOCKET_CFG_OFS;
  endsequence

  sequence s_insert0_wake;
    CE_I && insert_rise[0] && wake_en[0] && !FUNC_RST_I;
  endsequence

  sequence s_cfg_load;
    CE_I && EE_I.load && !BUS_I.wr
      && EE_I.addr == card_cfg_pkg::SOCKET_CFG_OFS;
  endsequence

  sequence s_class_rd;
    CE_I && BUS_I.rd && !EE_I.load
      && BUS_I.addr == card_cfg_pkg::CLASS_CODE_OFS;
  endsequence

  sequence s_irq_en_wr;
    CE_I && BUS_I.wr && !FUNC_RST_I
      && BUS_I.addr == card_cfg_pkg::IRQ_ENABLE_OFS;
  endsequence

  AST_CLASS_WRITE: assert property (
    s_class_wr |=> CLASS_CODE_O
      == ($past(BUS_I.wdata) & card_cfg_pkg::CLASS_CODE_WMASK))
    else $error("Class code copy did not take the written value");

  AST_CLASS_LOAD: assert property (
    s_class_load |=> CLASS_CODE_O
      == ($past(EE_I.data) & card_cfg_pkg::CLASS_CODE_WMASK))
    else $error("Class code copy did not take the loader value");

  AST_CLASS_LOW_ZERO: assert property (
    CLASS_CODE_O[5:0] == 6'h00)
    else $error("Class code low bits are not zero");

  AST_ALIAS_MATCHES_READ: assert property (
    s_cfg_rd |=> RD_DATA_O == ALIAS_CFG_O)
    else $error("Alias differs from register read value");

  AST_FUNC_RST_KEEPS_CFG: assert property (
    CE_I && FUNC_RST_I && !BUS_I.wr && !EE_I.load
      |=> $stable(ALIAS_CFG_O) && $stable(CLASS_CODE_O))
    else $error("Function reset disturbed the configuration");

  AST_DEDICATED_ONES: assert property (
    ALIAS_CFG_O[9:8] == 2'h3 && SOCKET_O.dedicated == 2'h3)
    else $error("Dedicated socket bits are not one");

  AST_SOCKET3_ZERO: assert property (
    (ALIAS_CFG_O & card_cfg_pkg::SKT3_MASK) == 32'h00000000)
    else $error("Socket 3 bits are not zero");

  AST_SOCKET2_ZERO: assert property (
    (ALIAS_CFG_O & card_cfg_pkg::SKT2_MASK) == 32'h00000000)
    else $error("Socket 2 bits are not zero");

  AST_CFG_WRITE: assert property (
    s_cfg_wr |=> ALIAS_CFG_O[31:28] == $past(BUS_I.wdata[31:28])
      && SOCKET_O.enable == $past(BUS_I.wdata[1:0]))
    else $error("Socket configuration write not stored");

  AST_FIELD_TIE: assert property (
    s_cfg_load |=> SOCKET_O.lowv == $past(EE_I.data[25:24])
      && SOCKET_O.highv == $past(EE_I.data[21:20])
      && SOCKET_O.payment == $past(EE_I.data[17:16])
      && SOCKET_O.aux == $past(EE_I.data[13:12]))
    else $error("Socket control outputs differ from loaded value");

  AST_WAKE_EVENT: assert property (
    s_insert0_wake |=> WAKE_O[0] && state_r.irq_status[0]
      && state_r.irq_status[2] ##1 (!WAKE_O[0] || !$past(CE_I)))
    else $error("Insertion did not raise one wake pulse");

  AST_NO_WAKE_DISABLED: assert property (
    CE_I && !wake_en[1] |=> !WAKE_O[1])
    else $error("Wake pulse without wake enable");

  AST_SET_BEATS_CLEAR: assert property (
    CE_I && insert_rise[1] && irq_clr[1] && !FUNC_RST_I
      |=> state_r.irq_status[1])
    else $error("Insertion lost to a simultaneous clear");

  AST_READ_ONE_CYCLE: assert property (
    CE_I && !BUS_I.rd |=> RD_DATA_O == 32'h00000000)
    else $error("Read data stands outside its cycle");

  AST_LOWV_WRITE: assert property (
    s_cfg_wr |=> SOCKET_O.lowv
      == $past(BUS_I.wdata[card_cfg_pkg::LOWV_LSB +: 2]))
    else $error("Low voltage class flags not stored");

  AST_HIGHV_WRITE: assert property (
    s_cfg_wr |=> SOCKET_O.highv
      == $past(BUS_I.wdata[card_cfg_pkg::HIGHV_LSB +: 2]))
    else $error("High voltage class flags not stored");

  AST_PAYMENT_WRITE: assert property (
    s_cfg_wr |=> SOCKET_O.payment
      == $past(BUS_I.wdata[card_cfg_pkg::PAYMENT_LSB +: 2]))
    else $error("Payment interface enables not stored");

  AST_AUX_WRITE: assert property (
    s_cfg_wr |=> SOCKET_O.aux
      == $past(BUS_I.wdata[card_cfg_pkg::AUX_LSB +: 2]))
    else $error("Auxiliary pin enables not stored");

  AST_WAKE_EN_WRITE: assert property (
    s_cfg_wr |=> SOCKET_O.wake
      == $past(BUS_I.wdata[card_cfg_pkg::WAKE_LSB +: 2]))
    else $error("Wake enables not stored");

  AST_ENABLE_WRITE: assert property (
    s_cfg_wr |=> SOCKET_O.enable
      == $past(BUS_I.wdata[card_cfg_pkg::ENABLE_LSB +: 2]))
    else $error("Socket enables not stored");

  AST_CLASS_READ: assert property (
    s_class_rd |=> RD_DATA_O == CLASS_CODE_O)
    else $error("Class code read differs from copy");

  AST_GLOBAL_RESET: assert property (
    disable iff (1'b0)
    RST_I |=> ALIAS_CFG_O == card_cfg_pkg::CFG_STATE_RST.socket_cfg
      && CLASS_CODE_O == card_cfg_pkg::CFG_STATE_RST.class_code)
    else $error("Global reset did not restore the defaults");

  AST_WAKE_ONE_PULSE: assert property (
    WAKE_O[1] |=> !WAKE_O[1] || !$past(CE_I))
    else $error("Wake pulse of socket 1 lasted too long");

  AST_WAKE_NEEDS_EVENT: assert property (
    CE_I && !insert_rise[0] |=> !WAKE_O[0])
    else $error("Wake pulse of socket 0 without insertion");

  AST_INSERT_STATUS: assert property (
    CE_I && insert_rise[1] && !FUNC_RST_I
      |=> state_r.irq_status[1])
    else $error("Insertion status not set");

  AST_FUNC_RST_CLEARS: assert property (
    CE_I && FUNC_RST_I |=> state_r.irq_status == card_cfg_pkg::IRQ_RST
      && state_r.irq_enable == card_cfg_pkg::IRQ_RST
      && WAKE_O == 2'h0)
    else $error("Function reset left interrupt state");

  AST_IRQ_EN_WRITE: assert property (
    s_irq_en_wr |=> state_r.irq_enable == $past(BUS_I.wdata[3:0]))
    else $error("Interrupt enable write not stored");

  AST_UNMAPPED_READ: assert property (
    CE_I && BUS_I.rd && BUS_I.addr != card_cfg_pkg::CLASS_CODE_OFS
      && BUS_I.addr != card_cfg_pkg::SOCKET_CFG_OFS
      && BUS_I.addr != card_cfg_pkg::IRQ_STATUS_OFS
      && BUS_I.addr != card_cfg_pkg::IRQ_ENABLE_OFS
      |=> RD_DATA_O == 32'h00000000)
    else $error("Unmapped read returned data");

  AST_STATUS_CLEAR: assert property (
    CE_I && irq_clr[0] && !insert_rise[0] |=> !state_r.irq_status[0])
    else $error("Status clear did not take");

endmodule : card_cfg_regs

// file: verif/tb_card_cfg_regs.sv
// Self-checking bench for the card socket configuration registers
`timescale 1ns/1ps
module tb_card_cfg_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic func_rst = 1'b0;
  card_cfg_pkg::bus_req_t bus = '0;
  card_cfg_pkg::ee_load_t ee = '0;
  logic [1:0] insert = 2'h0;
  logic [31:0] rd_data;
  logic [31:0] class_code;
  logic [31:0] alias_cfg;
  card_cfg_pkg::socket_ctl_t socket;
  logic [1:0] wake;
  logic irq;
  logic [31:0] exp_cfg;
  int err_count = 0;
  int checks_done = 0;
  int n;

  always #5 clk = ~clk;

  card_cfg_regs u_card_cfg_regs
  (
    .CLK_I(clk),
    .RST_I(rst),
    .CE_I(ce),
    .FUNC_RST_I(func_rst),
    .BUS_I(bus),
    .RD_DATA_O(rd_data),
    .EE_I(ee),
    .CARD_INSERT_I(insert),
    .CLASS_CODE_O(class_code),
    .ALIAS_CFG_O(alias_cfg),
    .SOCKET_O(socket),
    .WAKE_O(wake),
    .IRQ_O(irq)
  );

  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
    @(posedge clk);
    bus <= '0;
    #1;
    check($sformatf("read %h", a), rd_data, exp);
  endtask : rdchk

  task automatic ld(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ee <= '{load: 1'b1, addr: a, data: d};
    @(posedge clk);
    ee <= '0;
    #1;
  endtask : ld

  task automatic pulse_reset(input logic glob);
    @(posedge clk);
    if (glob)
      rst <= 1'b1;
    else
      func_rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    func_rst <= 1'b0;
    #1;
  endtask : pulse_reset

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("class out", class_code, 32'h07800000);
    rdchk(card_cfg_pkg::CLASS_CODE_OFS, 32'h07800000);
    rdchk(card_cfg_pkg::SOCKET_CFG_OFS, 32'h03303303);
    check("alias", alias_cfg, 32'h03303303);
    check("socket", {18'h0, socket}, 32'h00003f3c);
    // Walking one across the whole socket configuration word
    for (int i = 0; i < 32; i++)
    begin
      exp_cfg = ((32'h1 << i) & 32'hf3333033) | 32'h00000300;
      wr(card_cfg_pkg::SOCKET_CFG_OFS, 32'h1 << i);
      rdchk(card_cfg_pkg::SOCKET_CFG_OFS, exp_cfg);
      check("alias", alias_cfg, exp_cfg);
    end
    wr(card_cfg_pkg::SOCKET_CFG_OFS, 32'hffffffff);
    rdchk(card_cfg_pkg::SOCKET_CFG_OFS, 32'hf3333333);
    check("socket", {18'h0, socket}, 32'h00003fff);
    wr(card_cfg_pkg::SOCKET_CFG_OFS, 32'h00000000);
    check("socket", {18'h0, socket}, 32'h0000000c);
    wr(card_cfg_pkg::CLASS_CODE_OFS, 32'hffffffff);
    rdchk(card_cfg_pkg::CLASS_CODE_OFS, 32'hffffffc0);
    ld(8'h54, 32'h12345678);
    check("class out", class_code, 32'h12345640);
    ld(8'h58, 32'hffffffff);
    check("alias", alias_cfg, 32'hf3333333);
    ld(8'h50, 32'h00000000);
    check("alias", alias_cfg, 32'hf3333333);
    wr(8'h5c, 32'h00000000);
    rdchk(8'h5c, 32'h00000000);
    rdchk(card_cfg_pkg::SOCKET_CFG_OFS, 32'hf3333333);
    // Insertion on both sockets, wake only on socket 0
    wr(card_cfg_pkg::SOCKET_CFG_OFS, 32'h00000010);
    wr(card_cfg_pkg::IRQ_ENABLE_OFS, 32'h0000000f);
    @(posedge clk);
    insert <= 2'h3;
    n = 0;
    while (wake === 2'h0 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (wake === 2'h0)
      err_count++;
    check("wake", {30'h0, wake}, 32'h00000001);
    @(posedge clk);
    #1;
    check("wake", {30'h0, wake}, 32'h00000000);
    check("irq", {31'h0, irq}, 32'h00000001);
    rdchk(card_cfg_pkg::IRQ_STATUS_OFS, 32'h00000007);
    wr(card_cfg_pkg::IRQ_ENABLE_OFS, 32'h00000000);
    check("irq", {31'h0, irq}, 32'h00000000);
    wr(card_cfg_pkg::IRQ_ENABLE_OFS, 32'h0000000f);
    check("irq", {31'h0, irq}, 32'h00000001);
    wr(card_cfg_pkg::IRQ_CLEAR_OFS, 32'h0000000f);
    rdchk(card_cfg_pkg::IRQ_STATUS_OFS, 32'h00000000);
    check("irq", {31'h0, irq}, 32'h00000000);
    // Function reset keeps configuration, global reset restores it
    wr(card_cfg_pkg::SOCKET_CFG_OFS, 32'ha5a5a5a5);
    pulse_reset(1'b0);
    rdchk(card_cfg_pkg::SOCKET_CFG_OFS, 32'ha1212321);
    rdchk(card_cfg_pkg::CLASS_CODE_OFS, 32'h12345640);
    rdchk(card_cfg_pkg::IRQ_ENABLE_OFS, 32'h00000000);
    pulse_reset(1'b1);
    check("alias", alias_cfg, 32'h03303303);
    check("class out", class_code, 32'h07800000);
    // Frozen clock enable drops a write
    @(posedge clk);
    ce <= 1'b0;
    wr(card_cfg_pkg::SOCKET_CFG_OFS, 32'h00000000);
    @(posedge clk);
    ce <= 1'b1;
    rdchk(card_cfg_pkg::SOCKET_CFG_OFS, 32'h03303303);
    // Socket 1 insertion in the cycle of a clear, set wins
    @(posedge clk);
    insert <= 2'h0;
    repeat (4) @(posedge clk);
    insert <= 2'h2;
    @(posedge clk);
    wr(card_cfg_pkg::IRQ_CLEAR_OFS, 32'h0000000f);
    rdchk(card_cfg_pkg::IRQ_STATUS_OFS, 32'h00000002);
    print_verdict();
  end
endmodule : tb_card_cfg_regs
